// ### rtl/cpp_pkg.sv
// Shared constants and types for the charger power-path register bank
package cpp_pkg;
	// Register offsets
	localparam logic [7:0] OFS_CFG     = 8'h00;
	localparam logic [7:0] OFS_STAT    = 8'h01;
	localparam logic [7:0] OFS_GPIO    = 8'h1c;
	// Reset values and write masks
	localparam logic [7:0] CFG_RESET   = 8'hd9;
	localparam logic [7:0] CFG_WMASK   = 8'hdf;
	localparam logic [7:0] GPIO_RESET  = 8'h00;
	localparam logic       CE_RESET    = 1'b1;
	// Configuration field positions
	localparam int CFG_CE       = 0;
	localparam int CFG_INMAX    = 1;
	localparam int CFG_USB500   = 2;
	localparam int CFG_SCALE_LO = 3;
	localparam int CFG_SCALE_HI = 4;
	localparam int CFG_RUN      = 6;
	localparam int CFG_VSEL     = 7;
	localparam int GPIO_SAFETY  = 4;
	// Serial port constants; device address value is arbitrary
	localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
	localparam logic [3:0] BYTE_BITS    = 4'h8;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
	} cpp_i2c_state_e;

	// Analog status and event sources, all asynchronous
	typedef struct packed {
		logic       supEnter;
		logic       supExit;
		logic       usbSelected;
		logic       loopActive;
		logic       acDetect;
		logic       usbDetect;
		logic [1:0] chargeState;
		logic       inputOv;
		logic       undervoltage_lockout;
		logic       tempFault;
		logic       ldoInReg;
		logic       ldoAbove2v;
	} cpp_stat_in_s;

	// Controls to the analog charger and power path
	typedef struct packed {
		logic       sysFromInput;
		logic       chargeRun;
		logic       voltSel42;
		logic       voltSafety436;
		logic [1:0] currentScale;
		logic       usbLimit500;
		logic       inputLimitMax;
		logic       timerHold;
		logic       timerRestart;
		logic       statusValid;
		logic       detectValid;
		logic       statusEvent;
	} cpp_chg_ctrl_s;
endpackage

// ### rtl/cpp_charger_regs.sv
// Charger configuration, status and safety registers behind an I2C slave
//
// Behaviour
// - Status contents valid only with input power; regulator in regulation flags it.
// - Output undervoltage entry captures select bit into latch, then resets register bit.
// - During lockout with supply present, latch value drives charger and path switches.
// - Latch returns to high only when input power is removed.
// - Leaving lockout disables latch; register select bit drives switches directly.
// - Config bit 0 picks system source: 0 battery, 1 input power.
// - Config bit 7 picks charge voltage: 0 is 4.36 V, 1 is 4.2 V.
// - Config bit 6: 0 suspends charging, 1 allows it; bit 5 unused.
// - Config bits 4:3 current scaling: 00 gives 0.25, else external resistor.
// - Bit 2 USB limit 100/500 mA; bit 1 USB limit or maximum.
// - Shared register 0x1C bit 4 is charge voltage safety: 0 4.2 V, 1 4.36 V.
// - Status bit 7 supplement mode: set above 60 mV, cleared below 20 mV.
// - Supplement status bit is masked and never raises an event.
// - Status bit 6 selected input (0 AC, 1 USB); bit 5 loop active.
// - Status bits 4,3 AC and USB detected; trusted only above 2.0 V.
// - Status bits 2:1 charge state: fault/off, done, fast charge, precharge.
// - Status bit 0 reports overvoltage on AC or USB input.
// - Suspend by bit or temperature fault pauses safety timers; only the fault pauses them without restart.
// - Toggling select or suspend bits, or power cycling, restarts timers and faults.
`timescale 1ns/10ps
module cpp_charger_regs #(
	parameter logic [6:0] DEV_ADDR = cpp_pkg::DEV_ADDR_DEF
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// I2C pins
	input  wire logic                  sclIn,
	input  wire logic                  sdaIn,
	output logic                       sdaOut,
	output logic                       sdaOeN,
	// Analog side
	input  wire cpp_pkg::cpp_stat_in_s statIn,
	output cpp_pkg::cpp_chg_ctrl_s     ctrl
);
	cpp_pkg::cpp_stat_in_s   statS1, statS, statPrevQ;
	logic                    sclS1, sclS, sclQ, sdaS1, sdaS, sdaQ;
	cpp_pkg::cpp_i2c_state_e stateQ, stateD;
	logic [3:0]              cntQ, cntD;
	logic [7:0]              shiftQ, shiftD, txQ, txD, ptrQ, ptrD;
	logic                    sdaLowQ, sdaLowD, rwQ, rwD, wrStb;
	logic [7:0]              cfgQ, gpioQ;
	logic                    ceLatchQ, suppQ, uvloQ, inPresQ, ceQ, chgOnQ;
	cpp_pkg::cpp_chg_ctrl_s  ctrlD;

	// Two-stage synchronisers for pins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{sclS1, sclS, sclQ, sdaS1, sdaS, sdaQ} <= 6'h3f;
			statS1 <= '0;
			statS  <= '0;
		end else begin
			{sclS1, sclS, sclQ} <= {sclIn, sclS1, sclS};
			{sdaS1, sdaS, sdaQ} <= {sdaIn, sdaS1, sdaS};
			statS1 <= statIn;
			statS  <= statS1;
		end
	end

	wire sclRise  = sclS & ~sclQ;
	wire sclFall  = ~sclS & sclQ;
	wire startDet = sclS & sclQ & sdaQ & ~sdaS;
	wire stopDet  = sclS & sclQ & ~sdaQ & sdaS;
	wire byteDone = (cntQ == cpp_pkg::BYTE_BITS);
	wire inPres   = statS.acDetect | statS.usbDetect;
	wire uvloRise = statS.undervoltage_lockout & ~uvloQ;

	// Status byte, sampled live when a read byte is loaded
	wire [7:0] statByte = {suppQ, statS.usbSelected, statS.loopActive,
		statS.acDetect, statS.usbDetect,
		statS.chargeState, statS.inputOv};
	wire selCfg  = (ptrQ == cpp_pkg::OFS_CFG);
	wire selStat = (ptrQ == cpp_pkg::OFS_STAT);
	wire selGpio = (ptrQ == cpp_pkg::OFS_GPIO);
	wire [7:0] readMux = selCfg ? cfgQ : selStat ? statByte :
		selGpio ? gpioQ : cpp_pkg::READ_UNMAPPED;

	// Serial slave sequencing
	always_comb begin
		stateD  = stateQ;
		cntD    = cntQ;
		shiftD  = shiftQ;
		txD     = txQ;
		ptrD    = ptrQ;
		rwD     = rwQ;
		sdaLowD = sdaLowQ;
		wrStb   = 1'b0;
		if (startDet) begin
			stateD  = cpp_pkg::ST_ADDR;
			cntD    = '0;
			sdaLowD = 1'b0;
		end else if (stopDet) begin
			stateD  = cpp_pkg::ST_IDLE;
			sdaLowD = 1'b0;
		end else if (sclRise) begin
			case (stateQ)
				cpp_pkg::ST_ADDR, cpp_pkg::ST_PTR, cpp_pkg::ST_WDATA: begin
					shiftD = {shiftQ[6:0], sdaS};
					cntD   = cntQ + 4'h1;
				end
				cpp_pkg::ST_RACK: begin
					if (sdaS) begin
						stateD = cpp_pkg::ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (sclFall) begin
			case (stateQ)
				cpp_pkg::ST_ADDR: begin
					if (byteDone && shiftQ[7:1] == DEV_ADDR) begin
						stateD  = cpp_pkg::ST_AACK;
						rwD     = shiftQ[0];
						sdaLowD = 1'b1;
					end else if (byteDone) begin
						stateD = cpp_pkg::ST_IDLE;
					end
				end
				cpp_pkg::ST_PTR: begin
					if (byteDone) begin
						stateD  = cpp_pkg::ST_PACK;
						ptrD    = shiftQ;
						sdaLowD = 1'b1;
					end
				end
				cpp_pkg::ST_WDATA: begin
					if (byteDone) begin
						stateD  = cpp_pkg::ST_WACK;
						wrStb   = 1'b1;
						sdaLowD = 1'b1;
					end
				end
				cpp_pkg::ST_AACK, cpp_pkg::ST_RACK: begin
					cntD = '0;
					if (stateQ == cpp_pkg::ST_AACK && !rwQ) begin
						stateD  = cpp_pkg::ST_PTR;
						sdaLowD = 1'b0;
					end else begin
						stateD  = cpp_pkg::ST_RDATA;
						txD     = readMux;
						sdaLowD = ~readMux[7];
						cntD    = 4'h1;
					end
				end
				cpp_pkg::ST_PACK, cpp_pkg::ST_WACK: begin
					stateD  = cpp_pkg::ST_WDATA;
					cntD    = '0;
					sdaLowD = 1'b0;
				end
				cpp_pkg::ST_RDATA: begin
					if (byteDone) begin
						stateD  = cpp_pkg::ST_RACK;
						sdaLowD = 1'b0;
					end else begin
						txD     = {txQ[6:0], 1'b0};
						sdaLowD = ~txQ[6];
						cntD    = cntQ + 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stateQ  <= cpp_pkg::ST_IDLE;
			{cntQ, shiftQ, txQ, ptrQ} <= '0;
			{rwQ, sdaLowQ} <= 2'h0;
		end else begin
			stateQ  <= stateD;
			{cntQ, shiftQ, txQ, ptrQ} <= {cntD, shiftD, txD, ptrD};
			{rwQ, sdaLowQ} <= {rwD, sdaLowD};
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOeN = ~sdaLowQ;

	// Registers; lockout entry outranks a host write to the select bit
	wire [7:0] cfgWr  = (shiftQ & cpp_pkg::CFG_WMASK);
	wire [7:0] cfgHost = (wrStb && selCfg) ? cfgWr : cfgQ;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfgQ  <= cpp_pkg::CFG_RESET;
			gpioQ <= cpp_pkg::GPIO_RESET;
		end else begin
			cfgQ <= cfgHost;
			if (uvloRise) begin
				cfgQ[cpp_pkg::CFG_CE] <= cpp_pkg::CE_RESET;
			end
			if (wrStb && selGpio) begin
				gpioQ <= shiftQ;
			end
		end
	end

	// Select latch, supplement flag, edge history
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ceLatchQ <= cpp_pkg::CE_RESET;
			{suppQ, uvloQ, inPresQ} <= 3'h0;
			ceQ      <= cpp_pkg::CFG_RESET[cpp_pkg::CFG_CE];
			chgOnQ   <= cpp_pkg::CFG_RESET[cpp_pkg::CFG_RUN];
			statPrevQ <= '0;
		end else begin
			if (!inPres) begin
				ceLatchQ <= cpp_pkg::CE_RESET;
			end else if (uvloRise) begin
				ceLatchQ <= cfgQ[cpp_pkg::CFG_CE];
			end
			if (statS.supEnter) begin
				suppQ <= 1'b1;
			end else if (statS.supExit) begin
				suppQ <= 1'b0;
			end
			{uvloQ, inPresQ} <= {statS.undervoltage_lockout, inPres};
			ceQ      <= cfgQ[cpp_pkg::CFG_CE];
			chgOnQ   <= cfgQ[cpp_pkg::CFG_RUN];
			statPrevQ <= statS;
		end
	end

	// Control outputs to the analog side
	wire useLatch   = statS.undervoltage_lockout & inPres;
	wire cycleStart = (ceQ != cfgQ[cpp_pkg::CFG_CE]) ||
		(chgOnQ != cfgQ[cpp_pkg::CFG_RUN]) || (inPres && !inPresQ) || uvloRise;
	wire [6:0] evtNow  = statByte[6:0];
	wire [6:0] evtPrev = {statPrevQ.usbSelected, statPrevQ.loopActive, statPrevQ.acDetect,
		statPrevQ.usbDetect, statPrevQ.chargeState, statPrevQ.inputOv};
	always_comb begin
		ctrlD.sysFromInput  = useLatch ? ceLatchQ : cfgQ[cpp_pkg::CFG_CE];
		ctrlD.chargeRun     = cfgQ[cpp_pkg::CFG_RUN];
		ctrlD.voltSel42     = cfgQ[cpp_pkg::CFG_VSEL];
		ctrlD.voltSafety436 = gpioQ[cpp_pkg::GPIO_SAFETY];
		ctrlD.currentScale  = cfgQ[cpp_pkg::CFG_SCALE_HI:cpp_pkg::CFG_SCALE_LO];
		ctrlD.usbLimit500   = cfgQ[cpp_pkg::CFG_USB500];
		ctrlD.inputLimitMax = cfgQ[cpp_pkg::CFG_INMAX];
		ctrlD.timerHold     = ~cfgQ[cpp_pkg::CFG_RUN] | statS.tempFault;
		ctrlD.timerRestart  = cycleStart;
		ctrlD.statusValid   = statS.ldoInReg;
		ctrlD.detectValid   = statS.ldoAbove2v;
		ctrlD.statusEvent   = (evtNow != evtPrev);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl <= '0;
		end else begin
			ctrl <= ctrlD;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_uvloEntry;
		!statS.undervoltage_lockout ##1 statS.undervoltage_lockout && inPres;
	endsequence
	sequence s_capture;
		ceLatchQ == $past(cfgQ[cpp_pkg::CFG_CE]) && cfgQ[cpp_pkg::CFG_CE];
	endsequence
	sequence s_powerUp;
		!inPres ##1 inPres;
	endsequence

	a_latch_capture: assert property (s_uvloEntry |=> s_capture)
		else $error("select latch did not capture on lockout entry");
	a_latch_drives: assert property (useLatch |=> ctrl.sysFromInput == $past(ceLatchQ))
		else $error("latch not steering power path in lockout");
	a_latch_release: assert property (!inPres |=> ceLatchQ)
		else $error("latch not released with input removed");
	a_reg_drives: assert property (!statS.undervoltage_lockout |=>
		ctrl.sysFromInput == $past(cfgQ[cpp_pkg::CFG_CE]))
		else $error("register not steering power path outside lockout");
	a_supp_hyst: assert property (statS.supEnter |=> suppQ)
		else $error("supplement flag not set");
	a_supp_masked: assert property ($changed(suppQ) && $stable(evtNow) |=> !ctrl.statusEvent)
		else $error("supplement change raised an event");
	a_stat_readonly: assert property (wrStb && selStat && !uvloRise |=> $stable(cfgQ) && $stable(gpioQ))
		else $error("status write altered a register");
	a_timer_restart: assert property (wrStb && selCfg && !uvloRise &&
		cfgWr[cpp_pkg::CFG_RUN] != cfgQ[cpp_pkg::CFG_RUN] |=> ##1 ctrl.timerRestart)
		else $error("suspend toggle did not restart timers");
	a_timer_hold: assert property (statS.tempFault |=> ctrl.timerHold)
		else $error("timers not held during temperature fault");
	a_status_map: assert property (stateQ == cpp_pkg::ST_AACK && sclFall && rwQ && selStat
		|=> txQ == $past(statByte))
		else $error("status byte not loaded live");
	a_unused_zero: assert property ((cfgQ & ~cpp_pkg::CFG_WMASK) == '0)
		else $error("unused configuration bit set");
	a_supp_clear: assert property (statS.supExit && !statS.supEnter |=> !suppQ)
		else $error("supplement flag not cleared");
	a_safety_bit: assert property (gpioQ[cpp_pkg::GPIO_SAFETY] |=> ctrl.voltSafety436)
		else $error("safety voltage bit not driven");
	a_event_raise: assert property (evtNow != evtPrev |=> ctrl.statusEvent)
		else $error("status change raised no event");
	a_power_restart: assert property (s_powerUp |=> ctrl.timerRestart)
		else $error("input power return did not restart timers");
endmodule

// ### sim/cpp_i2c_host.sv
// I2C host model for the charger register bank
`timescale 1ns/10ps
module cpp_i2c_host #(
	parameter logic [6:0] ADDR = cpp_pkg::DEV_ADDR_DEF
) (
	// Open-drain bus
	input  wire logic devOeN,
	output logic      scl,
	output wire logic sda
);
	logic hostSda = 1'b1;
	initial scl = 1'b1;
	// Pull-up: released line reads high
	assign sda = hostSda & devOeN;
	task automatic bitOut(input logic b);
		hostSda = b;
		#40 scl = 1'b1;
		#80 scl = 1'b0;
		#40;
	endtask
	task automatic bitIn(output logic b);
		hostSda = 1'b1;
		#40 scl = 1'b1;
		#40 b = sda;
		#40 scl = 1'b0;
		#40;
	endtask
	task automatic start();
		hostSda = 1'b1;
		#40 scl = 1'b1;
		#40 hostSda = 1'b0;
		#40 scl = 1'b0;
		#40;
	endtask
	task automatic stop();
		hostSda = 1'b0;
		#40 scl = 1'b1;
		#40 hostSda = 1'b1;
		#40;
	endtask
	task automatic byteOut(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bitOut(d[i]);
		end
		bitIn(a);
		ack = ~a;
	endtask
	task automatic wrReg(input logic [7:0] p, input logic [7:0] d, output logic ack);
		logic a1, a2, a3;
		start();
		byteOut({ADDR, 1'b0}, a1);
		byteOut(p, a2);
		byteOut(d, a3);
		stop();
		ack = a1 & a2 & a3;
	endtask
	task automatic rdReg(input logic [7:0] p, output logic [7:0] d);
		logic a;
		start();
		byteOut({ADDR, 1'b0}, a);
		byteOut(p, a);
		start();
		byteOut({ADDR, 1'b1}, a);
		for (int i = 7; i >= 0; i--) begin
			bitIn(a);
			d[i] = a;
		end
		bitOut(1'b1);
		stop();
	endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the charger register bank
`timescale 1ns/10ps
module testbench;
	typedef struct packed {
		logic [7:0]            cfg;
		cpp_pkg::cpp_stat_in_s stat;
		logic [7:0]            expStat;
	} cpp_row_s;
	localparam logic [7:0] CFG = cpp_pkg::OFS_CFG;
	localparam logic [7:0] STA = cpp_pkg::OFS_STAT;
	localparam logic [7:0] GIO = cpp_pkg::OFS_GPIO;
	logic                   sys_clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   sdaOut, sdaOeN, scl, sda, ack;
	cpp_pkg::cpp_stat_in_s  statIn = '0;
	cpp_pkg::cpp_chg_ctrl_s ctrl;
	int                     fail_count = 0;
	int                     check_count = 0;
	int                     restarts = 0;
	int                     events = 0;
	int                     n;
	logic [7:0]             rd;
	cpp_row_s               rows [4] = '{'{8'h00, 13'h1103, 8'h90}, '{8'hff, 13'h04a3, 8'hca},
		'{8'h55, 13'h0b56, 8'h35}, '{8'haa, 13'h01e3, 8'h1e}};
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (ctrl.timerRestart === 1'b1) restarts++;
		if (ctrl.statusEvent === 1'b1) events++;
	end
	cpp_charger_regs uut (
		.sys_clk(sys_clk),
		.rst    (rst),
		.sclIn  (scl),
		.sdaIn  (sda),
		.sdaOut (sdaOut),
		.sdaOeN (sdaOeN),
		.statIn (statIn),
		.ctrl   (ctrl)
	);
	cpp_i2c_host host (
		.devOeN(sdaOeN),
		.scl   (scl),
		.sda   (sda)
	);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		@(negedge sys_clk);
		host.wrReg(p, d, ack);
		chk({7'h0, ack}, 8'h01);
	endtask
	task automatic rdChk(input logic [7:0] p, input logic [7:0] exp);
		@(negedge sys_clk);
		host.rdReg(p, rd);
		chk(rd, exp);
	endtask
	task automatic settle();
		repeat (10) @(negedge sys_clk);
	endtask
	function automatic logic [7:0] ctrlExp(input logic [7:0] c, input logic t);
		return {c[0], c[6], c[7], c[4:3], c[2], c[1], ~c[6] | t};
	endfunction
	initial begin
		#900000;
		fail_count++;
		results();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		settle();
		rdChk(CFG, cpp_pkg::CFG_RESET);
		rdChk(GIO, cpp_pkg::GPIO_RESET);
		for (int i = 0; i < 4; i++) begin
			statIn = rows[i].stat;
			wr(CFG, rows[i].cfg);
			rdChk(CFG, rows[i].cfg & 8'hdf);
			rdChk(STA, rows[i].expStat);
			chk({ctrl.sysFromInput, ctrl.chargeRun, ctrl.voltSel42, ctrl.currentScale,
				ctrl.usbLimit500, ctrl.inputLimitMax, ctrl.timerHold},
				ctrlExp(rows[i].cfg, rows[i].stat.tempFault));
			chk({6'h0, ctrl.statusValid, ctrl.detectValid}, {6'h0, rows[i].stat[1:0]});
		end
		// Read-only status, live value, unmapped pointer, foreign address
		wr(STA, 8'hff);
		rdChk(STA, 8'h1e);
		statIn.inputOv = 1'b1;
		rdChk(STA, 8'h1f);
		rdChk(8'h05, 8'h00);
		@(negedge sys_clk);
		host.start();
		host.byteOut(8'h20, ack);
		host.stop();
		chk({7'h0, ack}, 8'h00);
		chk({7'h0, sdaOut}, 8'h00);
		// Safety voltage bit
		wr(GIO, 8'h10);
		chk({7'h0, ctrl.voltSafety436}, 8'h01);
		rdChk(GIO, 8'h10);
		wr(GIO, 8'hef);
		chk({7'h0, ctrl.voltSafety436}, 8'h00);
		// Supplement flag never raises an event
		n = events;
		statIn.supEnter = 1'b1;
		settle();
		chk(8'(events - n), 8'h00);
		statIn.inputOv = 1'b0;
		settle();
		chk(8'(events - n), 8'h01);
		// Suspend toggle restarts timers, temperature fault only holds them
		n = restarts;
		wr(CFG, 8'hea);
		chk(8'(restarts - n), 8'h01);
		chk({7'h0, ctrl.timerHold}, 8'h00);
		statIn.tempFault = 1'b1;
		settle();
		chk({7'h0, ctrl.timerHold}, 8'h01);
		chk(8'(restarts - n), 8'h01);
		// Lockout latch
		wr(CFG, 8'hd8);
		statIn.undervoltage_lockout = 1'b1;
		settle();
		chk({7'h0, ctrl.sysFromInput}, 8'h00);
		rdChk(CFG, 8'hd9);
		statIn.undervoltage_lockout = 1'b0;
		settle();
		chk({7'h0, ctrl.sysFromInput}, 8'h01);
		wr(CFG, 8'hd8);
		statIn.undervoltage_lockout = 1'b1;
		settle();
		statIn.acDetect = 1'b0;
		statIn.usbDetect = 1'b0;
		settle();
		statIn.acDetect = 1'b1;
		wr(CFG, 8'hd8);
		settle();
		chk({7'h0, ctrl.sysFromInput}, 8'h01);
		results();
	end
endmodule
